//--- hdl/ssp_regs.svh
// ssp_regs.svh: constants of the serial port pin multiplexer.
// assumes inclusion by bare name from the package, design and bench files.
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

`define SSP_NPINS 6
`define SSP_PIN_CA 0
`define SSP_PIN_CB 1
`define SSP_PIN_FS 2
`define SSP_PIN_CK 3
`define SSP_PIN_RX 4
`define SSP_PIN_TX 5
`define SSP_CTRL_RESET 6'h00
`define SSP_DIR_RESET 6'h00
`define SSP_WORD_BITS 24
`define SSP_FIFO_DEPTH 8
`define SSP_CLK_NS 20
`define SSP_MIN_PHASES 6

`endif

//--- hdl/ssp_pkg.sv
// ssp_pkg.sv: types shared by the serial port pin multiplexer files.
// assumes ssp_regs.svh is on the include path.
`include "ssp_regs.svh"

package ssp_pkg;
    typedef logic [`SSP_NPINS-1:0] ssp_pins_t;

    typedef enum logic {
        SSP_MODE_SYNC,
        SSP_MODE_ASYNC
    } ssp_mode_e;

    typedef enum logic {
        SSP_CTL_FLAG,
        SSP_CTL_TXOUT
    } ssp_ctl_use_e;

    typedef struct packed {
        logic out;
        logic oe;
    } ssp_drive_s;

    typedef struct packed {
        ssp_pins_t ctrl;
        ssp_pins_t dir;
        ssp_pins_t gpio_out;
        ssp_mode_e mode;
        ssp_ctl_use_e use_a;
        ssp_ctl_use_e use_b;
        logic ck_out;
        logic fs_out;
    } ssp_cfg_s;
endpackage : ssp_pkg

//--- hdl/ssp_fifo.sv
// ssp_fifo.sv: small flip-flop FIFO with valid/ready on both sides.
// assumes a single clock, synchronous active-low reset and clock enable.
`timescale 1ns/1ns
`default_nettype none

module ssp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : next_ptr

    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= next_ptr(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= next_ptr(rd_ptr);
            end
            count <= next_count;
            // registered full flag, so the port leaves straight from a flop
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end
endmodule : ssp_fifo

`default_nettype wire

//--- hdl/ssp_pin_mux.sv
// ssp_pin_mux.sv: pin multiplexer of one synchronous serial port, with
// a small receive shifter and a transmit shifter fed through a FIFO.
// assumes pins arrive asynchronously; the outside resolves each pin
// from its out/oe pair. config comes from same-clock core logic.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_regs.svh"

module ssp_pin_mux #(
    parameter int WORD_BITS = `SSP_WORD_BITS,
    parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic stop_req,
    input wire logic cfg_we,
    input wire ssp_pkg::ssp_cfg_s cfg_in,
    input wire logic [`SSP_NPINS-1:0] pin_in,
    output logic [`SSP_NPINS-1:0] pin_out,
    output logic [`SSP_NPINS-1:0] pin_oe,
    output logic [`SSP_NPINS-1:0] gpio_in,
    input wire logic [WORD_BITS-1:0] tx_word,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx2_bit,
    input wire logic tx3_bit,
    output logic [WORD_BITS-1:0] rx_word,
    output logic rx_valid,
    output logic flag0_in,
    output logic flag1_in,
    output logic rx_clk_in,
    output logic rx_fs_in
);
    localparam int BW = $clog2(WORD_BITS + 1);
    // external clock needs six core phases per period; checked by the sender
    localparam int MIN_CK_NS = `SSP_MIN_PHASES * `SSP_CLK_NS / 2;

    ssp_pkg::ssp_cfg_s cfg;
    logic stopped;
    logic [`SSP_NPINS-1:0] sync1;
    logic [`SSP_NPINS-1:0] sync2;
    logic [`SSP_NPINS-1:0] prev;
    logic [`SSP_NPINS-1:0] next_out;
    logic [`SSP_NPINS-1:0] next_oe;
    logic ck_rise;
    logic ck_fall;
    logic fs_level;
    logic [WORD_BITS-1:0] rx_shift;
    logic [BW-1:0] rx_cnt;
    logic [WORD_BITS-1:0] tx_shift;
    logic [BW-1:0] tx_cnt;
    logic [WORD_BITS-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic tx_serial_on;
    logic rx_serial_on;

    function automatic logic is_serial(input ssp_pkg::ssp_cfg_s c, input int idx);
        is_serial = c.ctrl[idx];
    endfunction : is_serial

    // config register; reset leaves every pin a plain gpio input
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg <= '0;
            cfg.ctrl <= `SSP_CTRL_RESET;
            cfg.dir <= `SSP_DIR_RESET;
        end else if (clk_en && cfg_we && !stopped) begin
            cfg <= cfg_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stopped <= 1'b0;
        end else if (clk_en) begin
            stopped <= stop_req;
        end
    end

    // pins are asynchronous; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else if (clk_en) begin
            sync1 <= pin_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // bit clock edges, whether driven here or from outside
    assign ck_rise = sync2[`SSP_PIN_CK] && !prev[`SSP_PIN_CK];
    assign ck_fall = !sync2[`SSP_PIN_CK] && prev[`SSP_PIN_CK];
    assign fs_level = sync2[`SSP_PIN_FS];
    assign tx_serial_on = is_serial(cfg, `SSP_PIN_TX) && is_serial(cfg, `SSP_PIN_CK);
    assign rx_serial_on = is_serial(cfg, `SSP_PIN_RX) && is_serial(cfg, `SSP_PIN_CK)
        && cfg.mode == ssp_pkg::SSP_MODE_SYNC;

    // pin drive; in stop every output floats and holds nothing else
    always_comb begin
        next_out = cfg.gpio_out;
        next_oe = cfg.dir;
        if (is_serial(cfg, `SSP_PIN_CA)) begin
            if (cfg.mode == ssp_pkg::SSP_MODE_ASYNC) begin
                next_oe[`SSP_PIN_CA] = cfg.dir[`SSP_PIN_CA];
                next_out[`SSP_PIN_CA] = cfg.ck_out;
            end else begin
                next_oe[`SSP_PIN_CA] = cfg.use_a == ssp_pkg::SSP_CTL_TXOUT
                    || cfg.dir[`SSP_PIN_CA];
                next_out[`SSP_PIN_CA] = cfg.use_a == ssp_pkg::SSP_CTL_TXOUT
                    ? tx2_bit : cfg.gpio_out[`SSP_PIN_CA];
            end
        end
        if (is_serial(cfg, `SSP_PIN_CB)) begin
            if (cfg.mode == ssp_pkg::SSP_MODE_ASYNC) begin
                next_oe[`SSP_PIN_CB] = cfg.dir[`SSP_PIN_CB];
                next_out[`SSP_PIN_CB] = cfg.fs_out;
            end else begin
                next_oe[`SSP_PIN_CB] = cfg.use_b == ssp_pkg::SSP_CTL_TXOUT
                    || cfg.dir[`SSP_PIN_CB];
                next_out[`SSP_PIN_CB] = cfg.use_b == ssp_pkg::SSP_CTL_TXOUT
                    ? tx3_bit : cfg.gpio_out[`SSP_PIN_CB];
            end
        end
        if (is_serial(cfg, `SSP_PIN_FS)) begin
            next_out[`SSP_PIN_FS] = cfg.fs_out;
        end
        if (is_serial(cfg, `SSP_PIN_CK)) begin
            next_out[`SSP_PIN_CK] = cfg.ck_out;
        end
        if (is_serial(cfg, `SSP_PIN_RX)) begin
            next_oe[`SSP_PIN_RX] = 1'b0;
        end
        if (is_serial(cfg, `SSP_PIN_TX)) begin
            next_oe[`SSP_PIN_TX] = 1'b1;
            next_out[`SSP_PIN_TX] = tx_shift[WORD_BITS-1];
        end
        if (stopped) begin
            next_oe = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else if (clk_en) begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end

    // inputs as seen by core; frozen while stopped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gpio_in <= '0;
            flag0_in <= 1'b0;
            flag1_in <= 1'b0;
            rx_clk_in <= 1'b0;
            rx_fs_in <= 1'b0;
        end else if (clk_en && !stopped) begin
            gpio_in <= sync2 & ~cfg.ctrl;
            flag0_in <= is_serial(cfg, `SSP_PIN_CA) && cfg.mode == ssp_pkg::SSP_MODE_SYNC
                && sync2[`SSP_PIN_CA];
            flag1_in <= is_serial(cfg, `SSP_PIN_CB) && cfg.mode == ssp_pkg::SSP_MODE_SYNC
                && sync2[`SSP_PIN_CB];
            rx_clk_in <= is_serial(cfg, `SSP_PIN_CA) && cfg.mode == ssp_pkg::SSP_MODE_ASYNC
                && sync2[`SSP_PIN_CA];
            // in sync mode the shared frame sync also marks rx frames
            rx_fs_in <= cfg.mode == ssp_pkg::SSP_MODE_ASYNC
                ? (is_serial(cfg, `SSP_PIN_CB) && sync2[`SSP_PIN_CB])
                : (is_serial(cfg, `SSP_PIN_FS) && fs_level);
        end
    end

    // receive shifter: sample on rising bit clock, frame sync restarts word
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_shift <= '0;
            rx_cnt <= '0;
            rx_word <= '0;
            rx_valid <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= 1'b0;
            if (rx_serial_on && !stopped && ck_rise) begin
                rx_shift <= {rx_shift[WORD_BITS-2:0], sync2[`SSP_PIN_RX]};
                if (fs_level) begin
                    rx_cnt <= BW'(1);
                end else if (rx_cnt == BW'(WORD_BITS - 1)) begin
                    rx_cnt <= '0;
                    rx_word <= {rx_shift[WORD_BITS-2:0], sync2[`SSP_PIN_RX]};
                    rx_valid <= 1'b1;
                end else begin
                    rx_cnt <= rx_cnt + 1'b1;
                end
            end
        end
    end

    // transmit shifter: loads on frame sync, shifts on falling bit clock
    assign fifo_pop = tx_serial_on && !stopped && ck_fall && fs_level && tx_cnt == '0;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_shift <= '0;
            tx_cnt <= '0;
        end else if (clk_en && tx_serial_on && !stopped && ck_fall) begin
            if (fifo_pop) begin
                tx_shift <= fifo_valid ? fifo_data : '0;
                tx_cnt <= fifo_valid ? BW'(WORD_BITS) : '0;
            end else if (tx_cnt != '0) begin
                tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
                tx_cnt <= tx_cnt - 1'b1;
            end
        end
    end

    // a word waits here until a frame starts; full fifo stalls the source
    ssp_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_data(tx_word),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );
endmodule : ssp_pin_mux

`default_nettype wire

//--- verification/ssp_pin_mux_assertions.sv
// ssp_pin_mux_assertions.sv: port checker of the serial pin multiplexer.
// assumes one core_clk domain and a bench that holds cfg_in steady.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_regs.svh"

module ssp_pin_mux_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic stop_req,
    input wire logic cfg_we,
    input wire ssp_pkg::ssp_cfg_s cfg_in,
    input wire logic [`SSP_NPINS-1:0] pin_in,
    input wire logic [`SSP_NPINS-1:0] pin_out,
    input wire logic [`SSP_NPINS-1:0] pin_oe,
    input wire logic [`SSP_NPINS-1:0] gpio_in,
    input wire logic tx_ready,
    input wire logic rx_valid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // four edges: cfg load, pin register, then settled
    sequence s_hold;
        (clk_en && cfg_we && !stop_req && $stable(cfg_in))[*4];
    endsequence
    sequence s_stop;
        (clk_en && stop_req)[*6];
    endsequence
    property p_reset_quiet;
        $rose(rst_b) |-> pin_oe == 6'h00 && pin_out == 6'h00 && gpio_in == 6'h00 && tx_ready;
    endproperty
    property p_gpio_dir;
        s_hold |-> ((pin_oe ^ cfg_in.dir) & ~cfg_in.ctrl) == 6'h00;
    endproperty
    property p_gpio_drive;
        s_hold |-> ((pin_out ^ cfg_in.gpio_out) & cfg_in.dir & ~cfg_in.ctrl) == 6'h00;
    endproperty
    property p_gpio_sample;
        (clk_en && cfg_we && !stop_req && $stable(cfg_in) && $stable(pin_in))[*6]
            |-> ((gpio_in ^ pin_in) & ~cfg_in.ctrl) == 6'h00 && (gpio_in & cfg_in.ctrl) == 6'h00;
    endproperty
    property p_ctl_a;
        s_hold ##0 cfg_in.ctrl[0] |-> pin_oe[0] == (cfg_in.dir[0]
            | (cfg_in.mode == ssp_pkg::SSP_MODE_SYNC && cfg_in.use_a == ssp_pkg::SSP_CTL_TXOUT));
    endproperty
    property p_ctl_b;
        s_hold ##0 cfg_in.ctrl[1] |-> pin_oe[1] == (cfg_in.dir[1]
            | (cfg_in.mode == ssp_pkg::SSP_MODE_SYNC && cfg_in.use_b == ssp_pkg::SSP_CTL_TXOUT));
    endproperty
    property p_sync_pins;
        s_hold |-> ((pin_oe ^ cfg_in.dir) & 6'h0C) == 6'h00 && !(cfg_in.ctrl[4] && pin_oe[4]);
    endproperty
    property p_rx_pulse;
        rx_valid && clk_en |=> !rx_valid;
    endproperty
    property p_stop_tristate;
        s_stop |-> pin_oe == 6'h00;
    endproperty
    property p_stop_frozen;
        s_stop |=> $stable(gpio_in);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset");
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");
    a_gpio_drive: assert property (p_gpio_drive) else $error("gpio level wrong");
    a_gpio_sample: assert property (p_gpio_sample) else $error("gpio input wrong");
    a_ctl_a: assert property (p_ctl_a) else $error("control pin a direction wrong");
    a_ctl_b: assert property (p_ctl_b) else $error("control pin b direction wrong");
    a_sync_pins: assert property (p_sync_pins) else $error("sync pin direction wrong");
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid longer than a cycle");
    a_stop_tristate: assert property (p_stop_tristate) else $error("pin driven in stop");
    a_stop_frozen: assert property (p_stop_frozen) else $error("input moved in stop");
endmodule : ssp_pin_mux_chk

bind ssp_pin_mux ssp_pin_mux_chk chk (.core_clk, .rst_b, .clk_en, .stop_req, .cfg_we, .cfg_in,
    .pin_in, .pin_out, .pin_oe, .gpio_in, .tx_ready, .rx_valid);
`default_nettype wire

//--- verification/ssp_codec_model.sv
// ssp_codec_model.sv: far-side codec driving bit clock, frame sync, data.
// assumes the port's frame sync, bit clock and rx pins are inputs.
`timescale 1ns/1ns
`default_nettype none

module ssp_codec_model (
    input wire logic tx_line,
    output logic ck,
    output logic fs,
    output logic sd
);
    initial begin
        ck = 1'b0;
        fs = 1'b0;
        sd = 1'b0;
    end
    // 160 ns bit clock, still between frames; tx bits caught at falls
    task automatic frame(input logic [23:0] rxw, output logic [23:0] txw);
        #7;
        for (int i = 0; i < 25; i++) begin
            #40;
            fs = (i == 0);
            sd = (i < 24) ? rxw[23 - i] : ~sd;
            #40 ck = 1'b1;
            #80 ck = 1'b0;
            if (i > 0) txw = {txw[22:0], tx_line};
        end
        // released line goes back to the last data bit
        #40 sd = ~sd;
    endtask : frame
endmodule : ssp_codec_model
`default_nettype wire

//--- verification/ssp_pin_mux_test.sv
// ssp_pin_mux_test.sv: self-checking bench of the serial pin multiplexer.
// assumes the codec model and the checker bind are compiled with it.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_regs.svh"

module ssp_pin_mux_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic stop_req = 1'b0;
    logic cfg_we = 1'b0;
    ssp_pkg::ssp_cfg_s cfg_in = '0;
    logic [5:0] ext = 6'h00;
    logic [5:0] pin_in, pin_out, pin_oe, gpio_in;
    logic [23:0] tx_word = 24'h000000;
    logic [23:0] rx_word, got, txw;
    logic tx_valid = 1'b0;
    logic tx2_bit = 1'b0;
    logic tx3_bit = 1'b0;
    logic tx_ready, rx_valid, flag0_in, flag1_in, rx_clk_in, rx_fs_in, ck, fs, sd;
    logic [31:0] seed = 32'hD91F;
    int err_count = 0;
    int samples_checked = 0;
    int nrx = 0;

    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[5], sd, ck, fs, ext[1:0]});

    ssp_pin_mux uut (.core_clk, .rst_b, .clk_en, .stop_req, .cfg_we, .cfg_in, .pin_in,
        .pin_out, .pin_oe, .gpio_in, .tx_word, .tx_valid, .tx_ready, .tx2_bit, .tx3_bit,
        .rx_word, .rx_valid, .flag0_in, .flag1_in, .rx_clk_in, .rx_fs_in);
    ssp_codec_model cdc (.tx_line(pin_in[5]), .ck, .fs, .sd);

    initial forever #10 core_clk = ~core_clk;

    // pulse read mid-cycle, away from the edges that move it
    always @(negedge core_clk) begin
        if (rx_valid === 1'b1) begin
            got <= rx_word;
            nrx <= nrx + 1;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [5:0] exp_pin(input ssp_pkg::ssp_cfg_s c);
        return (c.dir & c.gpio_out) | (~c.dir & {ext[5], sd, ck, fs, ext[1:0]});
    endfunction : exp_pin

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic put_cfg(input ssp_pkg::ssp_cfg_s c);
        @(negedge core_clk);
        cfg_in = c;
        cfg_we = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : put_cfg

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    initial begin
        ssp_pkg::ssp_cfg_s c;
        logic [23:0] q[$];
        logic [23:0] rw;
        int n;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        check("oe after reset", pin_oe, 6'h00);
        check("gpio_in after reset", gpio_in, 6'h00);
        check("ready after reset", tx_ready, 1'b1);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            c = '0;
            c.dir = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : seed[5:0];
            c.gpio_out = seed[11:6];
            ext = seed[17:12];
            put_cfg(c);
            check("gpio oe", pin_oe, c.dir);
            check("gpio in", gpio_in, exp_pin(c));
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            c = '0;
            c.ctrl = 6'h03;
            c.mode = ssp_pkg::ssp_mode_e'(i[0]);
            ext = seed[5:0];
            put_cfg(c);
            check("ctl a in", i[0] ? rx_clk_in : flag0_in, ext[0]);
            check("ctl b in", i[0] ? rx_fs_in : flag1_in, ext[1]);
            check("serial gpio_in", gpio_in & 6'h03, 6'h00);
        end
        c = '0;
        c.ctrl = 6'h3F;
        c.use_a = ssp_pkg::SSP_CTL_TXOUT;
        c.use_b = ssp_pkg::SSP_CTL_TXOUT;
        tx2_bit = 1'b1;
        put_cfg(c);
        check("extra tx pins", {pin_oe[1:0], pin_out[1:0]}, 4'hD);
        n = 0;
        while (tx_ready === 1'b1 && n < 20) begin
            seed = lfsr(seed);
            tx_word = seed[23:0];
            tx_valid = 1'b1;
            q.push_back(seed[23:0]);
            @(negedge core_clk);
            n++;
        end
        tx_valid = 1'b0;
        check("fifo depth", n, `SSP_FIFO_DEPTH);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            rw = (i == 0) ? 24'hFFFFFF : seed[23:0];
            n = nrx;
            cdc.frame(rw, txw);
            repeat (10) @(negedge core_clk);
            check("rx count", nrx, n + 1);
            check("rx word", got, rw);
            check("tx word", txw, (i < 8) ? q[i] : 24'h000000);
        end
        check("fifo drained", tx_ready, 1'b1);
        // async mode with pins a, b, frame sync and bit clock driven
        c = '0;
        c.ctrl = 6'h0F;
        c.dir = 6'h0F;
        c.mode = ssp_pkg::SSP_MODE_ASYNC;
        c.ck_out = 1'b1;
        put_cfg(c);
        check("async drive", {pin_oe[3:0], pin_out[3:0]}, 8'hF9);
        check("async rx clock", rx_clk_in, 1'b1);
        check("async rx fs", rx_fs_in, 1'b0);
        c = '0;
        c.dir = 6'h3F;
        c.gpio_out = 6'h2A;
        put_cfg(c);
        stop_req = 1'b1;
        @(negedge core_clk);
        c.dir = 6'h00;
        cfg_in = c;
        ext = 6'h15;
        repeat (8) @(negedge core_clk);
        check("stop oe", pin_oe, 6'h00);
        check("stop gpio_in", gpio_in, 6'h2A);
        cfg_we = 1'b0;
        stop_req = 1'b0;
        repeat (6) @(negedge core_clk);
        check("cfg kept over stop", pin_oe, 6'h3F);
        // reset in mid-run must drop a configured port back to inputs
        rst_b = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        check("oe after second reset", pin_oe, 6'h00);
        // a load offered while the clock enable is low must wait
        c.dir = 6'h15;
        cfg_in = c;
        cfg_we = 1'b1;
        clk_en = 1'b0;
        repeat (4) @(negedge core_clk);
        check("oe frozen", pin_oe, 6'h00);
        clk_en = 1'b1;
        repeat (4) @(negedge core_clk);
        check("oe after enable", pin_oe, 6'h15);
        stop_test();
    end
endmodule : ssp_pin_mux_test
`default_nettype wire
